/* include/sism_pkg.sv */
package sism_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [15:0] STATUS_IDX = 16'h4011;
  localparam logic [15:0] MASK_IDX = 16'h4019;
  localparam logic [15:0] CMPDIR_IDX = 16'h4021;
  localparam logic [15:0] RAW_IDX = 16'h4022;

  localparam logic [31:0] STATUS_ADDR = {14'h0000, STATUS_IDX, 2'h0};
  localparam logic [31:0] MASK_ADDR = {14'h0000, MASK_IDX, 2'h0};
  localparam logic [31:0] CMPDIR_ADDR = {14'h0000, CMPDIR_IDX, 2'h0};
  localparam logic [31:0] RAW_ADDR = {14'h0000, RAW_IDX, 2'h0};

  // Bit positions shared by status, mask and raw registers
  localparam int SYSLOW_BIT = 15;
  localparam int SRCCHG_BIT = 14;
  localparam int USBCUR_BIT = 13;
  localparam int TIMEOUT_BIT = 11;
  localparam int READY_BIT = 8;
  localparam int CMP_LSB = 4;
  localparam int CMP_NUM = 4;

  // Implemented bits and group membership
  localparam logic [15:0] IMPL_BITS = 16'he9f0;
  localparam logic [15:0] TIMEOUT_GRP = 16'h0800;
  localparam logic [15:0] CONV_GRP = 16'h01f0;
  localparam logic [15:0] SUPPLY_GRP = 16'he000;

  // Reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'he9f0;
  localparam logic [3:0] CMPDIR_RST = 4'h0;

  // Event sources as seen by the block
  typedef struct packed {
    logic system_supply_low;
    logic source_change;
    logic usb_current;
    logic timeout;
    logic converter_ready;
    logic [3:0] comparator_above;
  } sism_src_t;

  // Primary interrupt summaries
  typedef struct packed {
    logic timeout_primary_irq;
    logic converter_primary_irq;
    logic supply_path_primary_irq;
  } sism_prim_t;

  // Bus handshake states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } sism_bus_st_t;

endpackage

/* src/sism_edge.sv */
`timescale 1ns/10ps
module sism_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src,
  input wire logic clr,
  output logic stat_ff,
  output logic nxt_stat
);

  logic prev_ff;
  logic arm_ff;
  logic rise;

  // Rising source level; ignored on the first edge after reset so a
  // source already high at release is not taken for an event
  assign rise = src & ~prev_ff & arm_ff;

  // Sticky set on a rising source; a new edge beats a clear
  always_comb begin
    nxt_stat = stat_ff;
    if (clr) begin
      nxt_stat = 1'b0;
    end
    if (rise) begin
      nxt_stat = 1'b1;
    end
  end

  // Edge detection armed from the second edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= 1'b0;
    end else begin
      arm_ff <= 1'b1;
    end
  end

  // Previous source level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= src;
    end
  end

  // Status flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

endmodule

/* src/sism_top.sv */
`timescale 1ns/10ps
module sism_top
  import sism_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire sism_src_t src,
  output sism_prim_t prim_irq_ff,
  output logic irq_ff
);

  sism_bus_st_t st_ff;
  sism_bus_st_t nxt_st;
  logic [15:0] mask_ff;
  logic [15:0] nxt_mask;
  logic [3:0] cmpdir_ff;
  logic [3:0] nxt_cmpdir;
  logic [15:0] stat_vec;
  logic [15:0] nxt_stat_vec;
  logic [15:0] src_vec;
  logic [15:0] clr_vec;
  logic [15:0] raw_vec;
  logic [3:0] cmp_trig;
  logic [15:0] live;
  logic access;
  logic fire;
  logic wr_fire;
  logic hit_status;
  logic hit_mask;
  logic hit_cmpdir;
  logic hit_raw;
  logic mapped;
  logic [31:0] rd_data;
  logic [15:0] lane_en;
  logic wr_status;
  logic wr_mask;
  logic wr_cmpdir;
  logic [15:0] timeout_live;
  logic [15:0] conv_live;
  logic [15:0] supply_live;
  sism_prim_t nxt_prim;
  logic nxt_irq;
  logic nxt_pready;
  logic nxt_pslverr;
  logic [31:0] nxt_prdata;
  logic start;
  logic [3:0] above_prev_ff;
  logic [3:0] cmp_pulse;

  // Comparator trigger: direction bit one means above threshold
  always_comb begin
    cmp_trig = cmpdir_ff & src.comparator_above;
    cmp_trig = cmp_trig | (~cmpdir_ff & ~src.comparator_above);
  end

  // Comparator outputs one edge back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above_prev_ff <= 4'h0;
    end else begin
      above_prev_ff <= src.comparator_above;
    end
  end

  // Comparator event: output crosses into the level its direction bit
  // selects; a direction write alone raises nothing
  always_comb begin
    cmp_pulse = 4'h0;
    for (int ci = 0; ci < CMP_NUM; ci++) begin
      if (cmpdir_ff[ci]) begin
        cmp_pulse[ci] = src.comparator_above[ci] & ~above_prev_ff[ci];
      end else begin
        cmp_pulse[ci] = ~src.comparator_above[ci] & above_prev_ff[ci];
      end
    end
  end

  // Source conditions placed at their status positions
  always_comb begin
    src_vec = 16'h0000;
    src_vec[SYSLOW_BIT] = src.system_supply_low;
    src_vec[SRCCHG_BIT] = src.source_change;
    src_vec[USBCUR_BIT] = src.usb_current;
    src_vec[TIMEOUT_BIT] = src.timeout;
    src_vec[READY_BIT] = src.converter_ready;
    src_vec[CMP_LSB +: CMP_NUM] = cmp_pulse;
  end

  // Live levels shown in the raw register; comparators show their
  // trigger level rather than the one-cycle crossing
  always_comb begin
    raw_vec = src_vec & IMPL_BITS;
    raw_vec[CMP_LSB +: CMP_NUM] = cmp_trig;
  end

  // Address decode, word aligned only
  always_comb begin
    hit_status = (paddr == STATUS_ADDR);
    hit_mask = (paddr == MASK_ADDR);
    hit_cmpdir = (paddr == CMPDIR_ADDR);
    hit_raw = (paddr == RAW_ADDR);
    mapped = hit_status | hit_mask | hit_cmpdir | hit_raw;
  end

  // Access phase seen, the first access edge and the completing edge
  assign access = psel & penable;
  assign start = access & (st_ff == ST_IDLE);
  assign fire = access & pready_ff & (st_ff == ST_RESP);
  assign wr_fire = fire & pwrite & mapped;

  // Per-register write strobes, valid only at the completing edge
  assign wr_status = wr_fire & hit_status;
  assign wr_mask = wr_fire & hit_mask;
  assign wr_cmpdir = wr_fire & hit_cmpdir;

  // Byte lanes of the 16-bit registers; the upper lanes hold no bits
  always_comb begin
    lane_en = 16'h0000;
    lane_en[7:0] = {8{pstrb[0]}};
    lane_en[15:8] = {8{pstrb[1]}};
  end

  // Write-one-clear strobes honour byte lanes; a zero leaves its bit
  // alone, so software clears only what it has serviced
  always_comb begin
    clr_vec = 16'h0000;
    if (wr_status) begin
      clr_vec = pwdata[15:0] & lane_en;
    end
    clr_vec = clr_vec & IMPL_BITS;
  end

  // One sticky edge-latched bit per implemented source
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_bit
      if (IMPL_BITS[gi]) begin : g_impl
        sism_edge u_edge (
          .pclk(pclk),
          .presetn(presetn),
          .src(src_vec[gi]),
          .clr(clr_vec[gi]),
          .stat_ff(stat_vec[gi]),
          .nxt_stat(nxt_stat_vec[gi])
        );
      end else begin : g_rsvd
        assign stat_vec[gi] = 1'b0;
        assign nxt_stat_vec[gi] = 1'b0;
      end
    end
  endgenerate

  // Mask register update, same layout as status
  always_comb begin
    nxt_mask = mask_ff;
    if (wr_mask) begin
      if (pstrb[0]) begin
        nxt_mask[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        nxt_mask[15:8] = pwdata[15:8];
      end
    end
    nxt_mask = nxt_mask & IMPL_BITS;
  end

  // Mask flops, every implemented bit set out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= MASK_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // Comparator direction register
  always_comb begin
    nxt_cmpdir = cmpdir_ff;
    if (wr_cmpdir && pstrb[0]) begin
      nxt_cmpdir = pwdata[3:0];
    end
  end

  // Direction flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpdir_ff <= CMPDIR_RST;
    end else begin
      cmpdir_ff <= nxt_cmpdir;
    end
  end

  // Unmasked pending bits from next-state values, so outputs
  // follow a clear or mask change on the same edge; the current
  // flops would leave the line up one cycle too long
  always_comb begin
    live = nxt_stat_vec & ~nxt_mask;
  end

  // Split the pending bits by primary group
  always_comb begin
    timeout_live = live & TIMEOUT_GRP;
    conv_live = live & CONV_GRP;
    supply_live = live & SUPPLY_GRP;
  end

  // Next primary levels and the combined line
  always_comb begin
    nxt_prim = '0;
    nxt_prim.timeout_primary_irq = |timeout_live;
    nxt_prim.converter_primary_irq = |conv_live;
    nxt_prim.supply_path_primary_irq = |supply_live;
    nxt_irq = |nxt_prim;
  end

  // Primary summaries per group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_irq_ff <= '0;
    end else begin
      prim_irq_ff <= nxt_prim;
    end
  end

  // Combined level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // Read multiplexer, unused bits read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_status) begin
      rd_data[15:0] = stat_vec;
    end
    if (hit_mask) begin
      rd_data[15:0] = mask_ff;
    end
    if (hit_cmpdir) begin
      rd_data[3:0] = cmpdir_ff;
    end
    if (hit_raw) begin
      rd_data[15:0] = raw_vec;
    end
  end

  // Bus state: one wait state in every access
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (access) begin
          nxt_st = ST_RESP;
        end
      end
      ST_RESP: begin
        nxt_st = ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  // State flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Response next values: answer one cycle into the access phase,
  // and zero otherwise so stale read data never lingers
  always_comb begin
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    if (start) begin
      nxt_pready = 1'b1;
      nxt_pslverr = ~mapped; // Unmapped or misaligned address
      if (!pwrite && mapped) begin
        nxt_prdata = rd_data;
      end
    end
  end

  // Ready flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
    end
  end

  // Error flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Read data flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

endmodule

/* tb/sism_chk.sv */
`timescale 1ns/10ps
module sism_chk
  import sism_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire sism_src_t src,
  input wire sism_prim_t prim_irq_ff,
  input wire logic irq_ff
);
  // Completed write, the only way a mask or clear can move an interrupt
  logic wr_done;
  assign wr_done = psel && penable && pready_ff && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_irq_summary: assert property (irq_ff == |prim_irq_ff)
    else $error("summary irq differs from groups");
  chk_timeout_rise: assert property ($rose(prim_irq_ff.timeout_primary_irq) |->
    ($past(src.timeout) && !$past(src.timeout, 2)) || $past(wr_done && paddr == MASK_ADDR))
    else $error("timeout irq rose without cause");
  chk_conv_rise: assert property ($rose(prim_irq_ff.converter_primary_irq) |->
    $past(src[4:0]) != $past(src[4:0], 2) || $past(wr_done && paddr == MASK_ADDR))
    else $error("converter irq rose without cause");
  chk_supply_rise: assert property ($rose(prim_irq_ff.supply_path_primary_irq) |->
    ($past(src[8:6]) & ~$past(src[8:6], 2)) != 3'h0 || $past(wr_done && paddr == MASK_ADDR))
    else $error("supply irq rose without cause");
  chk_irq_fall: assert property ($fell(irq_ff) |->
    $past(wr_done && (paddr == STATUS_ADDR || paddr == MASK_ADDR)))
    else $error("irq fell without a write");
  chk_reset_masked: assert property (!$past(presetn) |=> prim_irq_ff == 3'h0)
    else $error("irq after reset");
  chk_ready_wait: assert property (psel && !penable ##1 psel && penable |=> pready_ff)
    else $error("no ready after one wait");
  chk_ready_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
  chk_idle_data: assert property (!pready_ff |-> prdata_ff == 32'h0)
    else $error("read data outside answer");
endmodule
bind sism_top sism_chk sism_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata_ff, .pready_ff, .pslverr_ff, .src, .prim_irq_ff, .irq_ff);

/* tb/tb_sism_top.sv */
`timescale 1ns/10ps
module tb_sism_top;
  import sism_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata_ff, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready_ff, pslverr_ff, irq_ff;
  sism_src_t src = 9'h000;
  sism_prim_t prim_irq_ff;
  int bad_count = 0, cmp_count = 0;
  always #5 pclk = ~pclk;
  sism_top sism_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata_ff, .pready_ff, .pslverr_ff, .src, .prim_irq_ff, .irq_ff);
  // Verdict and end of run
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled at a rising edge;
  // outputs are read between edges, where they stand settled
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 20);
    if (pready_ff !== 1'b1) begin
      bad_count++;
      test_done();
    end
    rd = prdata_ff;
    er = pslverr_ff;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_reset;
    apb(1'b0, MASK_ADDR, 32'h0);
    check(rd, 32'h0000e9f0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(rd, 32'h0);
    check({28'h0, irq_ff, prim_irq_ff}, 32'h0);
    $display("reset test done");
  endtask
  // Comparators fall with direction zero, all else rises
  task automatic t_events;
    src <= 9'h1ff;
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(rd, 32'h0000e900);
    src <= 9'h1f0;
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(rd, 32'h0000e9f0);
    check({28'h0, irq_ff, prim_irq_ff}, 32'h0);
    $display("event test done");
  endtask
  // Unmask one group at a time, then clear it
  task automatic t_groups;
    logic [15:0] g[3] = '{TIMEOUT_GRP, CONV_GRP, SUPPLY_GRP};
    logic [15:0] rem = 16'he9f0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, MASK_ADDR, {16'h0, MASK_RST & ~g[i]});
      check({28'h0, irq_ff, prim_irq_ff}, 32'h8 | (32'h1 << (2 - i)));
      apb(1'b1, STATUS_ADDR, {16'h0, g[i]});
      rem = rem & ~g[i];
      check({28'h0, irq_ff, prim_irq_ff}, 32'h0);
      apb(1'b0, STATUS_ADDR, 32'h0);
      check(rd, {16'h0, rem});
    end
    $display("group test done");
  endtask
  // Timeout rises at the very edge its clear lands
  task automatic t_clash;
    src <= 9'h000;
    @(posedge pclk);
    fork
      apb(1'b1, STATUS_ADDR, 32'h0800);
      begin
        repeat (2) @(posedge pclk);
        src.timeout <= 1'b1;
      end
    join
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(rd, 32'h00000800);
    $display("clash test done");
  endtask
  task automatic t_bad;
    apb(1'b0, STATUS_ADDR + 32'h4, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    $display("unmapped test done");
  endtask
  // Direction one fires on a rising comparator; a mid-run reset restores all
  task automatic t_dir;
    apb(1'b1, CMPDIR_ADDR, 32'h0000000f);
    apb(1'b0, CMPDIR_ADDR, 32'h0);
    check(rd, 32'h0000000f);
    apb(1'b1, STATUS_ADDR, 32'h00000800);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(rd, 32'h0);
    src.comparator_above <= 4'hf;
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(rd, 32'h000000f0);
    apb(1'b0, RAW_ADDR, 32'h0);
    check(rd, 32'h000008f0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MASK_ADDR, 32'h0);
    check(rd, 32'h0000e9f0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, CMPDIR_ADDR, 32'h0);
    check(rd, 32'h0);
    $display("direction and reset test done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_groups();
    t_clash();
    t_bad();
    t_dir();
    test_done();
  end
endmodule
